// ---- design/esfr_pkg.sv ----
// Shared codes, field positions and carriers of the event status and readout block
package esfr_pkg;
  // Event flag positions inside status and enable mask
  localparam int unsigned BIT_OPC = 0;
  localparam int unsigned BIT_QRE = 2;
  localparam int unsigned BIT_EXE = 4;
  localparam int unsigned BIT_CME = 5;
  // Only these bits are implemented, the rest read as zero
  localparam logic [7:0] FLAG_MASK = 8'h35;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  // Decimal text helpers
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] DEC_HUNDRED = 8'h64;
  localparam logic [7:0] DEC_TEN = 8'h0a;
  // Function codes that address the harmonic buffer
  localparam logic [4:0] FUNC_VOLT_HARM = 5'h0e;
  localparam logic [4:0] FUNC_CURR_HARM = 5'h0f;

  // Decoded host operations
  typedef enum logic [2:0] {
    OP_SET_ENABLE, OP_QUERY_ENABLE, OP_QUERY_STATUS, OP_FUNCTION_QUERY, OP_HARMONIC_SELECT
  } esfr_op_e;

  // Measurement channels
  typedef enum logic [2:0] {
    CH_ONE, CH_TWO, CH_THREE, CH_NEUTRAL, CH_SUM
  } esfr_chan_e;

  // One decoded command from the text parser
  typedef struct packed {
    esfr_op_e   op;
    logic [7:0] arg;
    esfr_chan_e chan;
    logic [4:0] func;
  } esfr_cmd_s;

  // One reply: integer in decimal text, or an exponent-format float word
  typedef struct packed {
    logic        is_float;
    logic [7:0]  value;
    logic [23:0] text;
    logic [1:0]  ndigits;
    logic [31:0] fdata;
  } esfr_resp_s;

  // Selection sent to the measurement store
  typedef struct packed {
    esfr_chan_e chan;
    logic [4:0] func;
    logic [7:0] harm_order;
    logic       percent;
  } esfr_sel_s;
endpackage

// ---- design/esfr_top.sv ----
// Event status registers, serial poll summary and function data readout
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Enable mask query replies mask in decimal
// - Status query replies value zero to 53
// - Four flags: complete, query, execution, command
// - Summary bit set when status AND mask
// - Status register cleared after its query
// - Function query returns selected float value
// - New data flag, polled when enabled
// - First harmonic read after change is stale
// - Harmonic percent or absolute per configuration
module esfr_top (
  input  wire logic               clk_sys,        // System clock, 100 MHz
  input  wire logic               reset,          // Synchronous, active high
  input  wire logic               cmd_valid,      // Pulse: one decoded command
  input  wire esfr_pkg::esfr_cmd_s cmd,           // Command fields
  input  wire logic               evt_opc,        // Pulse: operation complete
  input  wire logic               evt_qre,        // Pulse: unterminated query error
  input  wire logic               evt_exe,        // Pulse: execution error
  input  wire logic               evt_cme,        // Pulse: command error
  input  wire logic               meas_new,       // Pulse: fresh measurement set
  input  wire logic               data_enable,    // Serial poll enable for new data
  input  wire logic               cfg_percent,    // Harmonics as percentage
  input  wire logic [31:0]        meas_data,      // Word for last selection
  output logic                    resp_valid,     // Pulse: reply ready
  output esfr_pkg::esfr_resp_s    resp,           // Reply contents
  output logic                    sel_valid,      // Pulse: fetch request
  output esfr_pkg::esfr_sel_s     sel,            // Fetch selection
  output logic                    esb,            // Event summary bit
  output logic                    new_data_flag,  // Data status new data bit
  output logic                    data_srq        // New data seen by serial poll
);

  // Turn a byte into three ASCII digits, leading zeros suppressed
  function automatic logic [25:0] to_decimal(input logic [7:0] v);
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    h = v / esfr_pkg::DEC_HUNDRED;
    t = (v % esfr_pkg::DEC_HUNDRED) / esfr_pkg::DEC_TEN;
    o = v % esfr_pkg::DEC_TEN;
    if (h != 8'h00) begin
      to_decimal = {h + esfr_pkg::ASCII_ZERO, t + esfr_pkg::ASCII_ZERO,
                    o + esfr_pkg::ASCII_ZERO, 2'h3};
    end else if (t != 8'h00) begin
      to_decimal = {8'h00, t + esfr_pkg::ASCII_ZERO, o + esfr_pkg::ASCII_ZERO, 2'h2};
    end else begin
      to_decimal = {16'h0000, o + esfr_pkg::ASCII_ZERO, 2'h1};
    end
  endfunction

  // Harmonic codes are served through the stale buffer
  function automatic logic is_harmonic(input logic [4:0] f);
    is_harmonic = (f == esfr_pkg::FUNC_VOLT_HARM) || (f == esfr_pkg::FUNC_CURR_HARM);
  endfunction

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LOAD} esfr_state_e;

  esfr_state_e         state;          // Readout sequencer
  esfr_state_e         next_state;
  logic [7:0]          status;         // Standard event status
  logic [7:0]          next_status;
  logic [7:0]          enable;         // Standard event enable mask
  logic [7:0]          next_enable;
  logic [7:0]          harm_order;     // Selected harmonic order
  logic [7:0]          next_harm_order;
  logic [31:0]         harm_buf;       // Last harmonic word, lags one read
  logic [31:0]         next_harm_buf;
  logic                pend_harm;      // Fetch is for a harmonic code
  logic                next_pend_harm;
  logic                next_new_data;
  logic                next_esb;
  logic                next_resp_valid;
  esfr_pkg::esfr_resp_s next_resp;
  logic                next_sel_valid;
  esfr_pkg::esfr_sel_s  next_sel;
  logic [7:0]          evt_bits;       // Incoming events at their positions
  logic [25:0]         dec;            // Decimal text of the queried byte

  // Event and register next values; events set in the clearing cycle survive
  always_comb begin
    evt_bits = 8'h00;
    evt_bits[esfr_pkg::BIT_OPC] = evt_opc;
    evt_bits[esfr_pkg::BIT_QRE] = evt_qre;
    evt_bits[esfr_pkg::BIT_EXE] = evt_exe;
    evt_bits[esfr_pkg::BIT_CME] = evt_cme;
    next_status = status;
    next_enable = enable;
    next_harm_order = harm_order;
    if (cmd_valid && cmd.op == esfr_pkg::OP_QUERY_STATUS) begin
      next_status = 8'h00;
    end
    next_status = (next_status | evt_bits) & esfr_pkg::FLAG_MASK;
    if (cmd_valid && cmd.op == esfr_pkg::OP_SET_ENABLE) begin
      next_enable = cmd.arg & esfr_pkg::FLAG_MASK;
    end
    if (cmd_valid && cmd.op == esfr_pkg::OP_HARMONIC_SELECT) begin
      next_harm_order = cmd.arg;
    end
    next_esb = |(next_status & next_enable);
    // new data set wins over clear
    next_new_data = new_data_flag;
    if (cmd_valid && cmd.op == esfr_pkg::OP_FUNCTION_QUERY) begin
      next_new_data = 1'b0;
    end
    next_new_data = next_new_data | meas_new;
  end

  // Reply and fetch sequencing
  always_comb begin
    next_state = state;
    next_harm_buf = harm_buf;
    next_pend_harm = pend_harm;
    next_resp_valid = 1'b0;
    next_resp = resp;
    next_sel_valid = 1'b0;
    next_sel = sel;
    dec = to_decimal(status);
    case (state)
      ST_IDLE: begin
        if (cmd_valid) begin
          case (cmd.op)
            esfr_pkg::OP_QUERY_ENABLE: begin
              dec = to_decimal(enable);
              next_resp = '{1'b0, enable, dec[25:2], dec[1:0], 32'h0000_0000};
              next_resp_valid = 1'b1;
            end
            esfr_pkg::OP_QUERY_STATUS: begin
              next_resp = '{1'b0, status, dec[25:2], dec[1:0], 32'h0000_0000};
              next_resp_valid = 1'b1;
            end
            esfr_pkg::OP_FUNCTION_QUERY: begin
              next_sel = '{cmd.chan, cmd.func, harm_order, cfg_percent};
              next_sel_valid = 1'b1;
              next_pend_harm = is_harmonic(cmd.func);
              next_state = ST_FETCH;
            end
            default: begin
              // Writes need no reply
              next_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_FETCH: begin
        // Store answers one cycle after the request
        next_state = ST_LOAD;
      end
      ST_LOAD: begin
        next_resp = '{1'b1, 8'h00, 24'h000000, 2'h0, meas_data};
        // harmonic reads return the previous word
        if (pend_harm) begin
          next_resp.fdata = harm_buf;
          next_harm_buf = meas_data;
        end
        next_resp_valid = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Register stage; commands arriving mid-fetch get no reply or fetch from the sequencer, but their register writes and clears still apply
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      status <= esfr_pkg::STATUS_RESET;
      enable <= esfr_pkg::ENABLE_RESET;
      harm_order <= 8'h00;
      harm_buf <= 32'h0000_0000;
      pend_harm <= 1'b0;
      esb <= 1'b0;
      new_data_flag <= 1'b0;
      data_srq <= 1'b0;
      resp_valid <= 1'b0;
      resp <= '0;
      sel_valid <= 1'b0;
      sel <= '0;
    end else begin
      state <= next_state;
      status <= next_status;
      enable <= next_enable;
      harm_order <= next_harm_order;
      harm_buf <= next_harm_buf;
      pend_harm <= next_pend_harm;
      esb <= next_esb;
      new_data_flag <= next_new_data;
      data_srq <= next_new_data & data_enable;
      resp_valid <= next_resp_valid;
      resp <= next_resp;
      sel_valid <= next_sel_valid;
      sel <= next_sel;
    end
  end

  // Checks
  sequence s_fq;
    cmd_valid && cmd.op == esfr_pkg::OP_FUNCTION_QUERY && state == ST_IDLE;
  endsequence

  esb_track_a: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 esb == |(status & enable)) else $error("summary bit wrong");
  enable_reply_a: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_valid && cmd.op == esfr_pkg::OP_QUERY_ENABLE && state == ST_IDLE
    |=> resp_valid && !resp.is_float && resp.value == $past(enable))
    else $error("enable reply wrong");
  status_reply_a: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_valid && cmd.op == esfr_pkg::OP_QUERY_STATUS && state == ST_IDLE
    |=> resp_valid && resp.value == $past(status)) else $error("status reply wrong");
  status_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_valid && cmd.op == esfr_pkg::OP_QUERY_STATUS && !evt_opc && !evt_qre && !evt_exe && !evt_cme
    |=> status == 8'h00) else $error("status not cleared");
  flag_bits_a: assert property (@(posedge clk_sys) disable iff (reset)
    (status & ~esfr_pkg::FLAG_MASK) == 8'h00) else $error("unused status bit set");
  event_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    evt_cme |=> status[esfr_pkg::BIT_CME]) else $error("command error lost");
  func_reply_a: assert property (@(posedge clk_sys) disable iff (reset)
    s_fq |=> sel_valid ##1 !resp_valid ##1 resp_valid && resp.is_float)
    else $error("function reply timing");
  harm_stale_a: assert property (@(posedge clk_sys) disable iff (reset)
    state == ST_LOAD && pend_harm |=> resp.fdata == $past(harm_buf) && harm_buf == $past(meas_data))
    else $error("harmonic buffer wrong");
  harm_pct_a: assert property (@(posedge clk_sys) disable iff (reset)
    s_fq |=> sel.percent == $past(cfg_percent)) else $error("percent select wrong");
  new_data_a: assert property (@(posedge clk_sys) disable iff (reset)
    meas_new |=> new_data_flag && data_srq == $past(data_enable)) else $error("new data lost");

endmodule

`default_nettype wire

// ---- sim/esfr_store_model.sv ----
// Measurement store model that answers fetch requests of the readout block
`timescale 1ns/1ps
`default_nettype none
module esfr_store_model (
  input  wire logic                clk_sys,   // System clock
  input  wire logic                sel_valid, // Pulse: fetch request
  input  wire esfr_pkg::esfr_sel_s sel,       // Fetch selection
  output logic [31:0]              meas_data  // Answer word
);
  // Known value until the first fetch
  initial meas_data = 32'h0;
  // word tied to the selection, valid only in the cycle after the request
  // Outside that cycle the word toggles, so a sample one cycle late reads the inverted word
  always @(posedge clk_sys) begin
    if (sel_valid) begin
      meas_data <= {2'h2, sel.harm_order, 3'h0, sel.chan, 3'h0, sel.func, 7'h00, sel.percent};
    end else begin
      meas_data <= ~meas_data;
    end
  end
endmodule
`default_nettype wire

// ---- sim/esfr_top_test.sv ----
// Self-checking bench of the event status and readout block
`timescale 1ns/1ps
`default_nettype none
module esfr_top_test;
  logic                 clk_sys = 1'b0;   // 100 MHz
  logic                 reset = 1'b1;     // Held 8 cycles
  logic                 cmd_valid = 1'b0; // Command strobe
  esfr_pkg::esfr_cmd_s  cmd = '0;         // Command fields
  logic [3:0]           evt = 4'h0;       // Complete, query, execution, command
  logic                 meas_new = 1'b0;  // Fresh data pulse
  logic                 data_enable = 1'b0;
  logic                 cfg_percent = 1'b0;
  logic [31:0]          meas_data;
  logic                 resp_valid, sel_valid, esb, new_data_flag, data_srq;
  esfr_pkg::esfr_resp_s resp;
  esfr_pkg::esfr_sel_s  sel;
  logic [7:0]           ord = 8'h00;      // Last harmonic order selected
  logic [31:0]          hbuf;             // Expected stale harmonic word
  logic                 hv = 1'b0;        // Stale buffer known yet
  int                   error_cnt = 0;
  int                   cmp_count = 0;
  int                   cyc = 0;

  always #5 clk_sys = ~clk_sys;

  esfr_top dut_u (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
    .evt_opc(evt[0]), .evt_qre(evt[1]), .evt_exe(evt[2]), .evt_cme(evt[3]),
    .meas_new(meas_new), .data_enable(data_enable), .cfg_percent(cfg_percent),
    .meas_data(meas_data), .resp_valid(resp_valid), .resp(resp), .sel_valid(sel_valid),
    .sel(sel), .esb(esb), .new_data_flag(new_data_flag), .data_srq(data_srq));
  esfr_store_model store_u (.clk_sys(clk_sys), .sel_valid(sel_valid), .sel(sel),
    .meas_data(meas_data));

  task automatic print_verdict();
    $display("Comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard, well above the fewer than one hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      $display("Error timeout expected below 2000 seen %0d", cyc);
      print_verdict();
    end
  end
  task automatic chk_word(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(string name, logic exp, logic got);
    chk_word(name, {31'h0, exp}, {31'h0, got});
  endtask
  // Inputs always move 1 ns after the rising edge
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic send(esfr_pkg::esfr_op_e op, logic [7:0] arg, esfr_pkg::esfr_chan_e ch,
                      logic [4:0] fn);
    tick();
    cmd_valid = 1'b1;
    cmd = '{op, arg, ch, fn};
    tick();
    cmd_valid = 1'b0;
  endtask
  task automatic pulse(int i);
    evt[i] = 1'b1;
    tick();
    evt[i] = 1'b0;
    tick();
  endtask
  // Integer query: the reply stands from the edge that takes the command until the next edge
  // Sizing the divisors to eight bits keeps each digit a byte before it is packed
  task automatic q_int(esfr_pkg::esfr_op_e op, logic [7:0] exp);
    logic [23:0] txt;
    logic [23:0] msk;
    logic [1:0]  nd;
    nd = (exp > 8'd99) ? 2'd3 : (exp > 8'd9) ? 2'd2 : 2'd1;
    msk = ~(24'hffffff << (8 * nd));
    txt = {8'h30 + exp / 8'd100, 8'h30 + exp / 8'd10 % 8'd10, 8'h30 + exp % 8'd10} & msk;
    send(op, 8'h00, esfr_pkg::CH_ONE, 5'h00);
    chk_bit("resp_valid", 1'b1, resp_valid);
    chk_bit("is_float", 1'b0, resp.is_float);
    chk_word("value", {24'h0, exp}, {24'h0, resp.value});
    chk_word("ndigits", {30'h0, nd}, {30'h0, resp.ndigits});
    chk_word("text", {8'h0, txt}, {8'h0, resp.text});
  endtask
  // Function query: fetch stands after the taking edge, float reply two edges later
  task automatic fq(esfr_pkg::esfr_chan_e ch, logic [4:0] fn);
    logic [31:0] exp;
    logic        harm;
    harm = (fn == esfr_pkg::FUNC_VOLT_HARM) || (fn == esfr_pkg::FUNC_CURR_HARM);
    exp = {2'h2, ord, 3'h0, ch, 3'h0, fn, 7'h00, cfg_percent};
    send(esfr_pkg::OP_FUNCTION_QUERY, 8'h00, ch, fn);
    chk_bit("sel_valid", 1'b1, sel_valid);
    chk_word("sel", {15'h0, ch, fn, ord, cfg_percent}, {15'h0, sel});
    tick();
    tick();
    chk_bit("resp_valid", 1'b1, resp_valid);
    chk_bit("is_float", 1'b1, resp.is_float);
    if (!harm || hv) chk_word("fdata", harm ? hbuf : exp, resp.fdata);
    if (harm) hbuf = exp;
    hv = hv | harm;
  endtask
  // each flag, summary bit, clear on read
  task automatic t_events();
    logic [7:0] pos [4] = '{8'h01, 8'h04, 8'h10, 8'h20};
    send(esfr_pkg::OP_SET_ENABLE, 8'hff, esfr_pkg::CH_ONE, 5'h00);
    q_int(esfr_pkg::OP_QUERY_ENABLE, 8'h35);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      chk_bit("esb_set", 1'b1, esb);
      q_int(esfr_pkg::OP_QUERY_STATUS, pos[i]);
      chk_bit("esb_clear", 1'b0, esb);
      q_int(esfr_pkg::OP_QUERY_STATUS, 8'h00);
    end
  endtask
  // unused enable bits dropped, summary follows the mask
  task automatic t_mask();
    send(esfr_pkg::OP_SET_ENABLE, 8'hda, esfr_pkg::CH_ONE, 5'h00);
    q_int(esfr_pkg::OP_QUERY_ENABLE, 8'h10);
    pulse(0);
    chk_bit("esb_masked", 1'b0, esb);
    pulse(2);
    chk_bit("esb_enabled", 1'b1, esb);
    q_int(esfr_pkg::OP_QUERY_STATUS, 8'h11);
  endtask
  // every channel, then the new data flag and its poll path
  task automatic t_func();
    send(esfr_pkg::OP_HARMONIC_SELECT, 8'h03, esfr_pkg::CH_ONE, 5'h00);
    ord = 8'h03;
    // channel one is read before the summation channel
    for (int c = 0; c < 5; c++) fq(esfr_pkg::esfr_chan_e'(c), 5'h03);
    data_enable = 1'b1;
    meas_new = 1'b1;
    tick();
    meas_new = 1'b0;
    chk_bit("new_data", 1'b1, new_data_flag);
    tick();
    chk_bit("data_srq", 1'b1, data_srq);
    data_enable = 1'b0;
    tick();
    chk_bit("data_srq_off", 1'b0, data_srq);
    fq(esfr_pkg::CH_ONE, 5'h00);
    chk_bit("new_data_clear", 1'b0, new_data_flag);
  endtask
  // first read after an order change is stale, percent follows setting
  task automatic t_harm();
    cfg_percent = 1'b1;
    fq(esfr_pkg::CH_TWO, esfr_pkg::FUNC_VOLT_HARM);
    send(esfr_pkg::OP_HARMONIC_SELECT, 8'h05, esfr_pkg::CH_ONE, 5'h00);
    ord = 8'h05;
    fq(esfr_pkg::CH_TWO, esfr_pkg::FUNC_VOLT_HARM);
    cfg_percent = 1'b0;
    fq(esfr_pkg::CH_NEUTRAL, esfr_pkg::FUNC_CURR_HARM);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    chk_bit("esb_reset", 1'b0, esb);
    q_int(esfr_pkg::OP_QUERY_ENABLE, 8'h00);
    q_int(esfr_pkg::OP_QUERY_STATUS, 8'h00);
    t_events();
    t_mask();
    t_func();
    t_harm();
    print_verdict();
  end
endmodule
`default_nettype wire
